//--- hdl/dpll_chan_map.svh
`ifndef DPLL_CHAN_MAP_SVH
`define DPLL_CHAN_MAP_SVH

// clock and timing
`define CLK_SYS_HZ       25000000
`define SNAP_STEP_S      1
`define SEC_CNT_W        25

// sizes
`define NUM_REFS         8
`define REF_IDX_W        3
`define OFFSET_W         24
`define BW_TABLE_LAST    5'h19

// register byte offsets
`define REG_OPMODE       8'h00
`define REG_REFSEL       8'h04
`define REG_REFEN        8'h08
`define REG_PRIO         8'h0c
`define REG_GROUP        8'h10
`define REG_LOOPBW       8'h14
`define REG_SNAPRATE     8'h18
`define REG_MANHOLD      8'h1c
`define REG_STATUS       8'h20
`define REG_HOLDVAL      8'h24

// field positions
`define OPMODE_LSB       0
`define HOLDTYPE_LSB     2
`define SELMODE_LSB      0
`define MANREF_LSB       4
`define SLAVEREF_LSB     8
`define BWREQ_LSB        0
`define DAMP_LSB         8
`define STAT_SEL_LSB     4
`define STAT_AVAIL_BIT   7

// operating mode codes
`define OPM_AUTO         2'h0
`define OPM_FLOCK        2'h1
`define OPM_FFREE        2'h2
`define OPM_FHOLD        2'h3

// holdover type codes
`define HOT_SIMPLE       2'h0
`define HOT_ADVANCED     2'h1
`define HOT_MANUAL       2'h2

// reference select mode codes
`define SEL_AUTO         4'h0
`define SEL_MANUAL       4'h1
`define SEL_PINMAN       4'h2
`define SEL_SLAVE        4'h3
`define SEL_PINSLAVE     4'h4

// reset values
`define RST_OPMODE       4'h0
`define RST_REFSEL       12'h000
`define RST_REFEN        8'hff
`define RST_PRIO         32'h76543210
`define RST_GROUP        32'h00000000
`define RST_BWREQ        5'h0d
`define RST_DAMP         4'h4
`define RST_SNAPRATE     6'h01

`endif

//--- hdl/dpll_chan_pkg.sv
package dpll_chan_pkg;
    typedef enum logic [2:0] {
        FREE_RUN,
        LOCK_ACQUIRE,
        LOCKED,
        HOLDOVER,
        LOCK_RECOVER
    } chan_state_t;
endpackage

//--- hdl/dpll_reference_select_holdover.sv
// Function
// - locked loop follows frequency and phase of the selected reference
// - bandwidth and damping are programmable, applied while locked to a reference
// - bandwidth request maps to the nearest supported setting not above it
// - all usable references invalid moves the channel to holdover
// - simple holdover uses the offset captured just before entry
// - advanced holdover keeps two periodic snapshots, loads the older on entry
// - snapshot refresh interval programmable 0 to 63 seconds, one-second steps
// - forced holdover stays in holdover despite valid references
// - manual holdover forces holdover with a software-written offset
// - channel runs its own selection and may pick any input
// - four-bit mode field: automatic, manual, pin manual, slave, pin slave
// - automatic mode: qualified means enabled and declared valid by monitors
// - automatic mode picks the highest priority qualified input
// - group table makes several inputs one equal-priority group
// - manual mode uses register or pin choice, monitors never change it
// - manual mode: selected input invalid means holdover, never a switch
// - slave mode uses only the designated master input
// - pin slave behaves as master until the slave pin asserts
// - reset gives free-run, then acquire on selection, locked on lock
// - from holdover a qualified input leads through lock recovery
// - operating mode: automatic, forced locked, forced free-run, forced holdover
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dpll_chan_map.svh"

module dpll_reference_select_holdover #(
    parameter int unsigned SECOND_CYCLES = `SNAP_STEP_S * `CLK_SYS_HZ
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic [7:0]                regAddr,
    input  wire logic [31:0]               regWdata,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic      [31:0]               regRdata,
    input  wire logic [`NUM_REFS-1:0]      refValid,
    input  wire logic                      loopLocked,
    input  wire logic [`OFFSET_W-1:0]      filteredOffset,
    input  wire logic [`REF_IDX_W-1:0]     pinRefSel,
    input  wire logic                      pinSlave,
    output logic      [`REF_IDX_W-1:0]     selectedRef,
    output logic                           refTracking,
    output dpll_chan_pkg::chan_state_t     chanState,
    output logic      [`OFFSET_W-1:0]      holdoverValue,
    output logic                           integratorLoad,
    output logic      [4:0]                bandwidthCode,
    output logic      [3:0]                dampingCode
);
    import dpll_chan_pkg::*;

    localparam int N = `NUM_REFS;

    logic                  rstMeta_q;
    logic                  rstSync_n;
    logic [N-1:0]          validMeta_q;
    logic [N-1:0]          validSync_q;
    logic [2:0]            pinSelMeta_q;
    logic [2:0]            pinSelSync_q;
    logic                  pinSlaveMeta_q;
    logic                  pinSlaveSync_q;

    logic [3:0]            opmode_q;
    logic [11:0]           refsel_q;
    logic [N-1:0]          refEn_q;
    logic [31:0]           prio_q;
    logic [31:0]           group_q;
    logic [4:0]            bwReq_q;
    logic [3:0]            damp_q;
    logic [5:0]            snapRate_q;
    logic [`OFFSET_W-1:0]  manHold_q;

    chan_state_t           state_q;
    chan_state_t           state_d;
    logic [`SEC_CNT_W-1:0] secCnt_q;
    logic [5:0]            secElapsed_q;
    logic [`OFFSET_W-1:0]  lastOffset_q;
    logic [`OFFSET_W-1:0]  snapNew_q;
    logic [`OFFSET_W-1:0]  snapOld_q;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_n <= rstMeta_q;
        end
    end

    // monitor flags and pins come from other domains: two flops each
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            validMeta_q    <= '0;
            validSync_q    <= '0;
            pinSelMeta_q   <= '0;
            pinSelSync_q   <= '0;
            pinSlaveMeta_q <= 1'b0;
            pinSlaveSync_q <= 1'b0;
        end else begin
            validMeta_q    <= refValid;
            validSync_q    <= validMeta_q;
            pinSelMeta_q   <= pinRefSel;
            pinSelSync_q   <= pinSelMeta_q;
            pinSlaveMeta_q <= pinSlave;
            pinSlaveSync_q <= pinSlaveMeta_q;
        end
    end

    // register field decode
    wire logic [1:0] opMode   = opmode_q[`OPMODE_LSB +: 2];
    wire logic [1:0] holdType = opmode_q[`HOLDTYPE_LSB +: 2];
    wire logic [3:0] selMode  = refsel_q[`SELMODE_LSB +: 4];
    wire logic [2:0] manRef   = refsel_q[`MANREF_LSB +: 3];
    wire logic [2:0] slaveRef = refsel_q[`SLAVEREF_LSB +: 3];

    wire logic [N-1:0] qualified = refEn_q & validSync_q;

    // priority search; lower value wins, a group takes its best member
    logic [3:0]    grpKey [N];
    logic [3:0]    bestKey;
    logic [2:0]    bestIdx;
    logic          bestFound;
    always_comb begin
        bestKey   = 4'hf;
        bestIdx   = 3'h0;
        bestFound = 1'b0;
        for (int i = 0; i < N; i++) begin
            grpKey[i] = prio_q[i*4 +: 4];
            if (group_q[i*4 +: 4] != 4'h0) begin
                for (int j = 0; j < N; j++) begin
                    if (qualified[j] && group_q[j*4 +: 4] == group_q[i*4 +: 4]
                        && prio_q[j*4 +: 4] < grpKey[i]) begin
                        grpKey[i] = prio_q[j*4 +: 4];
                    end
                end
            end
        end
        for (int i = 0; i < N; i++) begin
            if (qualified[i] && (!bestFound || grpKey[i] < bestKey)) begin
                bestFound = 1'b1;
                bestKey   = grpKey[i];
                bestIdx   = 3'(i);
            end
        end
        // an equal-priority tie keeps the current reference, avoiding needless switches
        if (bestFound && qualified[selectedRef] && grpKey[selectedRef] == bestKey) begin
            bestIdx = selectedRef;
        end
    end

    // mode decode; any reserved code falls through to automatic
    wire logic modeManual = (selMode == `SEL_MANUAL);
    wire logic modePinMan = (selMode == `SEL_PINMAN);
    // pin slave acts as master until the slave pin is seen
    wire logic modeSlave  = (selMode == `SEL_SLAVE)
                          || (selMode == `SEL_PINSLAVE && pinSlaveSync_q);
    wire logic modeFixed  = modeManual || modePinMan || modeSlave;

    wire logic [2:0] candRef = modeSlave  ? slaveRef :
                               modeManual ? manRef :
                               modePinMan ? pinSelSync_q : bestIdx;
    // fixed choices only check the monitors, they never move the choice
    wire logic candAvail = modeFixed ? validSync_q[candRef] : bestFound;
    wire logic refChanged = (candRef != selectedRef);

    // forced operating modes override the automatic machine
    wire logic forceHold = (opMode == `OPM_FHOLD) || (holdType == `HOT_MANUAL);

    // channel state machine
    always_comb begin
        state_d = state_q;
        if (forceHold) begin
            state_d = HOLDOVER;
        end else if (opMode == `OPM_FLOCK) begin
            state_d = LOCKED;
        end else if (opMode == `OPM_FFREE) begin
            state_d = FREE_RUN;
        end else begin
            unique case (state_q)
                // free-run until a usable input is selected
                FREE_RUN: begin
                    if (candAvail) state_d = LOCK_ACQUIRE;
                end
                LOCK_ACQUIRE: begin
                    if (!candAvail) state_d = FREE_RUN;
                    else if (loopLocked && !refChanged) state_d = LOCKED;
                end
                // nothing usable left: hold the stored frequency
                LOCKED: begin
                    if (!candAvail) state_d = HOLDOVER;
                    else if (refChanged) state_d = LOCK_ACQUIRE;
                end
                // recovery passes through its own state
                HOLDOVER: begin
                    if (candAvail) state_d = LOCK_RECOVER;
                end
                LOCK_RECOVER: begin
                    if (!candAvail) state_d = HOLDOVER;
                    else if (loopLocked && !refChanged) state_d = LOCKED;
                end
            endcase
        end
    end

    wire logic enterHold  = (state_d == HOLDOVER) && (state_q != HOLDOVER);
    wire logic inLocked   = (state_q == LOCKED);
    wire logic secTick    = (secCnt_q == `SEC_CNT_W'(SECOND_CYCLES - 1));
    // zero interval refreshes every cycle, otherwise every N seconds
    wire logic snapStrobe = (snapRate_q == 6'h00)
                          || (secTick && secElapsed_q >= snapRate_q - 6'h01);

    // clamp to the top of the supported table
    wire logic [4:0] bwEff = (bwReq_q > `BW_TABLE_LAST) ? `BW_TABLE_LAST : bwReq_q;

    // register writes
    wire logic wrOpmode  = regWr && regAddr == `REG_OPMODE;
    wire logic wrRefsel  = regWr && regAddr == `REG_REFSEL;
    wire logic wrRefen   = regWr && regAddr == `REG_REFEN;
    wire logic wrPrio    = regWr && regAddr == `REG_PRIO;
    wire logic wrGroup   = regWr && regAddr == `REG_GROUP;
    wire logic wrLoopbw  = regWr && regAddr == `REG_LOOPBW;
    wire logic wrSnap    = regWr && regAddr == `REG_SNAPRATE;
    wire logic wrManhold = regWr && regAddr == `REG_MANHOLD;

    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            opmode_q   <= `RST_OPMODE;
            refsel_q   <= `RST_REFSEL;
            refEn_q    <= `RST_REFEN;
            prio_q     <= `RST_PRIO;
            group_q    <= `RST_GROUP;
            bwReq_q    <= `RST_BWREQ;
            damp_q     <= `RST_DAMP;
            snapRate_q <= `RST_SNAPRATE;
            manHold_q  <= '0;
        end else begin
            if (wrOpmode)  opmode_q   <= regWdata[3:0];
            if (wrRefsel)  refsel_q   <= regWdata[11:0];
            if (wrRefen)   refEn_q    <= regWdata[N-1:0];
            if (wrPrio)    prio_q     <= regWdata;
            if (wrGroup)   group_q    <= regWdata;
            if (wrLoopbw)  bwReq_q    <= regWdata[`BWREQ_LSB +: 5];
            if (wrLoopbw)  damp_q     <= regWdata[`DAMP_LSB +: 4];
            if (wrSnap)    snapRate_q <= regWdata[5:0];
            if (wrManhold) manHold_q  <= regWdata[`OFFSET_W-1:0];
        end
    end

    // read mux; unmapped addresses read zero
    wire logic [31:0] rdMux =
        (regAddr == `REG_OPMODE)   ? {28'h0, opmode_q} :
        (regAddr == `REG_REFSEL)   ? {20'h0, refsel_q} :
        (regAddr == `REG_REFEN)    ? {24'h0, refEn_q} :
        (regAddr == `REG_PRIO)     ? prio_q :
        (regAddr == `REG_GROUP)    ? group_q :
        (regAddr == `REG_LOOPBW)   ? {20'h0, damp_q, 3'h0, bwReq_q} :
        (regAddr == `REG_SNAPRATE) ? {26'h0, snapRate_q} :
        (regAddr == `REG_MANHOLD)  ? {8'h0, manHold_q} :
        (regAddr == `REG_STATUS)   ? {24'h0, candAvail, selectedRef, 1'b0, state_q} :
        (regAddr == `REG_HOLDVAL)  ? {8'h0, holdoverValue} : 32'h0;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) regRdata <= '0;
        else            regRdata <= regRd ? rdMux : 32'h0;
    end

    // state and reference selection
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_q     <= FREE_RUN;
            selectedRef <= '0;
        end else begin
            state_q <= state_d;
            // holdover on loss of all inputs freezes the last choice; forced holdover still follows the candidate
            if (candAvail) selectedRef <= candRef;
        end
    end

    // the loop tracks the selected reference in the reference-following states
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) refTracking <= 1'b0;
        else refTracking <= (state_d == LOCKED || state_d == LOCK_ACQUIRE
                             || state_d == LOCK_RECOVER) && candAvail;
    end

    // settings reach the loop filter only while locked; acquisition keeps the old ones
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            bandwidthCode <= `RST_BWREQ;
            dampingCode   <= `RST_DAMP;
        end else if (inLocked) begin
            bandwidthCode <= bwEff;
            dampingCode   <= damp_q;
        end
    end

    // one-second time base, runs only while locked so snapshots reflect lock
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            secCnt_q     <= '0;
            secElapsed_q <= '0;
        end else if (!inLocked) begin
            secCnt_q     <= '0;
            secElapsed_q <= '0;
        end else if (secTick) begin
            secCnt_q     <= '0;
            secElapsed_q <= snapStrobe ? 6'h00 : secElapsed_q + 6'h01;
        end else begin
            secCnt_q <= secCnt_q + `SEC_CNT_W'(1);
        end
    end

    // last offset while locked; two-deep snapshot history
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            lastOffset_q <= '0;
            snapNew_q    <= '0;
            snapOld_q    <= '0;
        end else if (inLocked) begin
            lastOffset_q <= filteredOffset;
            if (snapStrobe) begin
                snapNew_q <= filteredOffset;
                snapOld_q <= snapNew_q;
            end
        end
    end

    // holdover value and integrator load pulse on entry
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            holdoverValue  <= '0;
            integratorLoad <= 1'b0;
        end else begin
            integratorLoad <= enterHold;
            // manual value follows software while held
            if (holdType == `HOT_MANUAL && state_d == HOLDOVER) begin
                holdoverValue <= manHold_q;
            end else if (enterHold && holdType == `HOT_ADVANCED) begin
                holdoverValue <= snapOld_q;
            end else if (enterHold) begin
                holdoverValue <= lastOffset_q;
            end
        end
    end

    assign chanState = state_q;

endmodule

`default_nettype wire

//--- tb/ref_loop_model.sv
`timescale 1ns/1ps
`default_nettype none

module ref_loop_model #(
    parameter int LOCK_CYCLES = 4
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  refsUp,
    input  wire logic        slowLock,
    input  wire logic [23:0] offsetSet,
    input  wire logic        refTracking,
    output logic      [7:0]  refValid,
    output logic             loopLocked,
    output logic      [23:0] filteredOffset
);
    int lockCnt_q;

    // monitors report straight from the stimulus, unrelated to the channel's sampling
    assign refValid = refsUp;
    assign filteredOffset = offsetSet;

    // lock detect needs a settled run of tracking; slow mode stretches it eightfold
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lockCnt_q <= 0;
        end else if (!refTracking) begin
            lockCnt_q <= 0;
        end else if (lockCnt_q < 64) begin
            lockCnt_q <= lockCnt_q + 1;
        end
    end
    assign loopLocked = lockCnt_q >= (slowLock ? 8 * LOCK_CYCLES : LOCK_CYCLES);
endmodule

`default_nettype wire

//--- tb/dpll_rsh_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpll_chan_map.svh"

module dpll_rsh_asserts
    import dpll_chan_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic [7:0]  refValid,
    input wire logic        loopLocked,
    input wire logic        refTracking,
    input wire chan_state_t chanState,
    input wire logic        integratorLoad,
    input wire logic [4:0]  bandwidthCode,
    input wire logic [3:0]  dampingCode
);
    logic [3:0] opMode_q;
    wire        autoOp;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // shadow of the operating mode so checks know when the machine runs free
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            opMode_q <= 4'h0;
        end else if (regWr && regAddr == `REG_OPMODE) begin
            opMode_q <= regWdata[3:0];
        end
    end
    assign autoOp = opMode_q[1:0] == `OPM_AUTO && opMode_q[3:2] != `HOT_MANUAL;

    a_load_entry: assert property (
        chanState == HOLDOVER && $past(chanState) != HOLDOVER |-> integratorLoad ##1 !integratorLoad)
        else $error("no single load pulse at holdover entry");
    a_load_only: assert property (
        integratorLoad |-> chanState == HOLDOVER && $past(chanState) != HOLDOVER)
        else $error("load pulse outside holdover entry");
    a_force_hold: assert property (
        (opMode_q[1:0] == `OPM_FHOLD) [*4] |-> chanState == HOLDOVER)
        else $error("forced holdover left");
    a_manual_hold: assert property (
        (opMode_q[3:2] == `HOT_MANUAL) [*4] |-> chanState == HOLDOVER)
        else $error("manual holdover not held");
    a_force_lock: assert property (
        (opMode_q[1:0] == `OPM_FLOCK && opMode_q[3:2] != `HOT_MANUAL) [*4] |-> chanState == LOCKED)
        else $error("forced locked not held");
    a_no_ref_hold: assert property (
        (autoOp && refValid == 8'h00) [*5] |-> chanState inside {FREE_RUN, HOLDOVER})
        else $error("tracking with no valid input");
    a_recover_path: assert property (
        $past(chanState) == HOLDOVER && chanState != HOLDOVER && autoOp && $past(autoOp)
        |-> chanState == LOCK_RECOVER)
        else $error("holdover left without recovery");
    a_acquire_first: assert property (
        $past(chanState) == FREE_RUN && chanState != FREE_RUN && autoOp && $past(autoOp)
        |-> chanState == LOCK_ACQUIRE)
        else $error("free run left without acquire");
    a_lock_cause: assert property (
        chanState == LOCKED && $past(chanState) != LOCKED && autoOp && $past(autoOp)
        |-> $past(loopLocked))
        else $error("locked without lock detect");
    a_bw_frozen: assert property (
        $past(chanState) != LOCKED |-> $stable(bandwidthCode) && $stable(dampingCode))
        else $error("loop settings changed out of lock");
    a_bw_range: assert property (
        bandwidthCode <= `BW_TABLE_LAST)
        else $error("bandwidth index beyond table");

    c_recover: cover property (chanState == LOCK_RECOVER);
    c_load: cover property (integratorLoad);
    c_locked: cover property (chanState == LOCKED && refTracking);
endmodule

`default_nettype wire

//--- tb/dpll_reference_select_holdover_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpll_chan_map.svh"

module dpll_reference_select_holdover_tb;
    import dpll_chan_pkg::*;
    logic        clk_sys, rst_n, regWr, regRd, pinSlave, slowLock;
    logic        loopLocked, refTracking, integratorLoad;
    logic [7:0]  regAddr, refsUp, refValid;
    logic [31:0] regWdata, regRdata;
    logic [23:0] offsetSet, filteredOffset, holdoverValue;
    logic [2:0]  pinRefSel, selectedRef;
    logic [4:0]  bandwidthCode;
    logic [3:0]  dampingCode;
    chan_state_t chanState;
    int          mismatches, num_checks;
    int          bwReq[3] = '{3, 25, 31};
    logic [3:0]  opm[4] = '{4'h3, 4'h2, 4'h1, 4'h8};
    chan_state_t opSt[4] = '{HOLDOVER, FREE_RUN, LOCKED, HOLDOVER};
    logic [31:0] selCode[5] = '{32'h051, 32'h002, 32'h403, 32'h40f, 32'h404};
    logic [2:0]  selExp[5] = '{3'h5, 3'h3, 3'h4, 3'h0, 3'h0};

    dpll_reference_select_holdover #(.SECOND_CYCLES(10)) dpll_reference_select_holdover_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .refValid(refValid),
        .loopLocked(loopLocked), .filteredOffset(filteredOffset), .pinRefSel(pinRefSel),
        .pinSlave(pinSlave), .selectedRef(selectedRef), .refTracking(refTracking),
        .chanState(chanState), .holdoverValue(holdoverValue),
        .integratorLoad(integratorLoad), .bandwidthCode(bandwidthCode),
        .dampingCode(dampingCode));
    ref_loop_model ref_loop_model_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .refsUp(refsUp), .slowLock(slowLock),
        .offsetSet(offsetSet), .refTracking(refTracking), .refValid(refValid),
        .loopLocked(loopLocked), .filteredOffset(filteredOffset));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe, so sample it there
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 check(regRdata, exp);
        // hand back on a rising edge so the caller's next drive lands on it
        @(posedge clk_sys);
    endtask
    // bounded wait for a state and reference; a timeout ends the run
    task automatic await(input chan_state_t s, input logic [2:0] r);
        int n;
        n = 0;
        while ((chanState !== s || selectedRef !== r) && n < 400) begin
            @(posedge clk_sys);
            #1 n++;
        end
        check({chanState, selectedRef}, {s, r});
        if (chanState !== s || selectedRef !== r) complete_run();
        @(posedge clk_sys);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        {rst_n, regWr, regRd, pinSlave, slowLock, regAddr, regWdata} = '0;
        {refsUp, offsetSet, pinRefSel} = '0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdchk(`REG_REFEN, 32'hff); // enables all set
        rdchk(`REG_PRIO, 32'h76543210); // priority defaults
        rdchk(`REG_GROUP, 32'h0); // no groups
        rdchk(`REG_SNAPRATE, 32'h1); // one second
        rdchk(8'h3c, 32'h0);
        rdchk(`REG_STATUS, 32'h0); // free run
        check(bandwidthCode, 32'h0d); // default bandwidth
        $display("test reset done");
        refsUp <= 8'h06;
        await(LOCKED, 3'h1); // best priority wins
        check(refTracking, 1'b1); // loop follows input
        wr(`REG_REFEN, 32'hfd);
        await(LOCKED, 3'h2); // disabled input skipped
        wr(`REG_GROUP, 32'h110);
        wr(`REG_REFEN, 32'hff);
        repeat (8) @(posedge clk_sys);
        #1 check(selectedRef, 3'h2); // group tie kept
        wr(`REG_GROUP, 32'h0);
        await(LOCKED, 3'h1); // reverts to better input
        foreach (bwReq[i]) begin
            wr(`REG_LOOPBW, 32'(bwReq[i]) | (32'(i + 5) << 8));
            repeat (3) @(posedge clk_sys);
            check({dampingCode, bandwidthCode}, {4'(i + 5), 5'(bwReq[i] > 25 ? 25 : bwReq[i])}); // clamped index
        end
        $display("test auto select done");
        slowLock <= 1'b1;
        offsetSet <= 24'h123456;
        repeat (4) @(posedge clk_sys);
        refsUp <= 8'h00;
        await(HOLDOVER, 3'h1); // all inputs lost
        check(holdoverValue, 32'h123456); // last offset kept
        check(refTracking, 1'b0); // no reference followed
        rdchk(`REG_HOLDVAL, 32'h123456); // offset readable
        refsUp <= 8'h02;
        await(LOCK_RECOVER, 3'h1); // recovery first
        await(LOCKED, 3'h1); // then locked
        $display("test simple holdover done");
        wr(`REG_SNAPRATE, 32'h7f);
        rdchk(`REG_SNAPRATE, 32'h3f); // six-bit interval
        wr(`REG_SNAPRATE, 32'h1);
        wr(`REG_OPMODE, 32'h4);
        offsetSet <= 24'h0a0a0a;
        repeat (40) @(posedge clk_sys);
        offsetSet <= 24'h0b0b0b;
        refsUp <= 8'h00;
        await(HOLDOVER, 3'h1);
        check(holdoverValue, 32'h0a0a0a); // older snapshot loaded
        refsUp <= 8'h02;
        await(LOCKED, 3'h1);
        $display("test advanced holdover done");
        wr(`REG_MANHOLD, 32'habcdef);
        foreach (opm[i]) begin
            wr(`REG_OPMODE, 32'(opm[i]));
            await(opSt[i], 3'h1); // forced states reached
        end
        check(holdoverValue, 32'habcdef); // software offset used
        wr(`REG_OPMODE, 32'h0);
        await(LOCKED, 3'h1);
        $display("test forced modes done");
        slowLock <= 1'b0;
        refsUp <= 8'h3f;
        pinRefSel <= 3'h3;
        foreach (selCode[i]) begin
            wr(`REG_REFSEL, selCode[i]);
            await(LOCKED, selExp[i]); // each select mode
        end
        repeat (4) @(posedge clk_sys);
        check(selectedRef, 3'h0); // master role until pin
        pinSlave <= 1'b1;
        await(LOCKED, 3'h4); // slave pin takes over
        refsUp <= 8'h2f;
        await(HOLDOVER, 3'h4); // only master input used
        refsUp <= 8'h3f;
        wr(`REG_REFSEL, 32'h051);
        await(LOCKED, 3'h5);
        refsUp <= 8'h1f;
        await(HOLDOVER, 3'h5); // no switch in manual
        $display("test select modes done");
        complete_run();
    end
endmodule

bind dpll_reference_select_holdover dpll_rsh_asserts dpll_rsh_asserts_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .refValid(refValid), .loopLocked(loopLocked),
    .refTracking(refTracking), .chanState(chanState), .integratorLoad(integratorLoad),
    .bandwidthCode(bandwidthCode), .dampingCode(dampingCode));

`default_nettype wire
